// File: shared/ddic_pkg.sv
// Purpose: Constants, register map and state type of the drive control block
// Assumes: 40 MHz pclk; every time below is converted to pclk cycles here
// Notes:   Long counts are defaults of top-level parameters

package ddic_pkg;

  // ---------------------------------------------------------------------
  // Clock and timing
  // ---------------------------------------------------------------------
  localparam int CLK_KHZ        = 40000;
  localparam int STEP_TIME_US   = 3000;  // Timed track-to-track interval
  localparam int STEP_CYC       = STEP_TIME_US * CLK_KHZ / 1000;
  localparam int SETTLE_US      = 3000;  // Head settling after a move
  localparam int SETTLE_CYC     = SETTLE_US * CLK_KHZ / 1000;
  localparam int QUIET_US       = 500;   // Longest buffered pulse spacing
  localparam int QUIET_CYC      = QUIET_US * CLK_KHZ / 1000;
  localparam int MOVE_US        = 100;   // Carriage time per cylinder
  localparam int MOVE_CYC       = MOVE_US * CLK_KHZ / 1000;
  localparam int TRK0_LEAD_NS   = 30000; // Outer flag leads ready by less
  localparam int TRK0_LEAD_CYC  = TRK0_LEAD_NS * CLK_KHZ / 1000000 - 1;
  localparam int FLUX_KBPS      = 5000;  // Serial flux data rate
  localparam int FLUX_CELL_CYC  = CLK_KHZ / FLUX_KBPS;
  localparam int NODATA_CELLS   = 16;    // Silent cells before a fault
  localparam int NODATA_CYC     = NODATA_CELLS * FLUX_CELL_CYC;

  // ---------------------------------------------------------------------
  // Geometry
  // ---------------------------------------------------------------------
  localparam int          CYL_COUNT = 645;
  localparam int          CYL_W     = 10;
  localparam logic [9:0]  CYL_MAX   = 10'(CYL_COUNT - 1);
  localparam int          HEAD_W    = 3;
  localparam int          NUM_HEADS = 7;

  // ---------------------------------------------------------------------
  // Register map, fields and reset values
  // ---------------------------------------------------------------------
  localparam logic [11:0] REG_CTRL    = 12'h000;
  localparam logic [11:0] REG_STATUS  = 12'h004;
  localparam logic [11:0] REG_CYL     = 12'h008;
  localparam logic [11:0] REG_FAULT   = 12'h00C;
  localparam int          CTRL_UNIT   = 0;  // Bits 1:0 unit address
  localparam int          CTRL_RADIAL = 2;
  localparam logic [1:0]  RST_UNIT    = 2'h0;
  localparam logic        RST_RADIAL  = 1'h0;
  localparam int          ST_READY    = 0;
  localparam int          ST_SEEKDONE = 1;
  localparam int          ST_TRK0     = 2;
  localparam int          ST_FAULT    = 3;
  localparam int          ST_SEL      = 4;
  localparam int          ST_BUFFERED = 5;
  localparam int          ST_WREN     = 6;
  localparam int          ST_STATE    = 8;  // Bits 10:8
  localparam int          ST_HEADS    = 16; // Bits 23:16
  localparam int          CYL_CUR     = 0;  // Bits 9:0
  localparam int          CYL_TGT     = 16; // Bits 25:16

  typedef enum logic [2:0] {
    ddic_spinup, ddic_recal, ddic_gap, ddic_online, ddic_travel, ddic_settle
  } ddic_state_t;

endpackage : ddic_pkg

// File: core/ddic_timer.sv
// Purpose: Loadable down counter with a one-cycle expiry pulse
// Assumes: A load of zero never fires
// Notes:   A new start restarts the count at once

`timescale 1ns/100ps
`default_nettype none

module ddic_timer #(
  parameter int W = 8
) (
  input  wire logic         pclk,
  input  wire logic         presetn,
  input  wire logic         start,
  input  wire logic [W-1:0] load,
  output logic              busy,
  output logic              fire
);

  typedef struct packed {
    logic [W-1:0] cnt;
    logic         fire;
  } ddic_tmr_t;

  ddic_tmr_t q, d;

  // Count down and flag the step from one to zero
  always_comb
  begin
    d      = q;
    d.fire = 1'b0;
    if (start)
      d.cnt = load;
    else if (q.cnt != '0)
    begin
      d.cnt  = q.cnt - W'(1);
      d.fire = (q.cnt == W'(1));
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      q <= '0;
    else
      q <= d;
  end

  assign busy = (q.cnt != '0);
  assign fire = q.fire;

endmodule : ddic_timer

`default_nettype wire

// File: core/ddic_step_mon.sv
// Purpose: Seek pulse edge detect and spacing classifier
// Assumes: step_n is synchronous to pclk and active low
// Notes:   Spacing counter saturates so an old pulse reads as long ago

`timescale 1ns/100ps
`default_nettype none

module ddic_step_mon #(
  parameter int W         = 18,
  parameter int STEP_CYC  = 120000,
  parameter int QUIET_CYC = 20000
) (
  input  wire logic pclk,
  input  wire logic presetn,
  input  wire logic step_n,
  output logic      pulse,
  output logic      fast,
  output logic      quiet
);

  typedef struct packed {
    logic         prev_n;
    logic [W-1:0] gap;
  } ddic_smon_t;

  ddic_smon_t q, d;

  // Leading edge is the high-to-low change of the line
  assign pulse = q.prev_n & ~step_n;
  assign fast  = pulse && (q.gap < W'(STEP_CYC));
  assign quiet = (q.gap >= W'(QUIET_CYC));

  // Cycles since the last leading edge
  always_comb
  begin
    d        = q;
    d.prev_n = step_n;
    if (pulse)
      d.gap = '0;
    else if (q.gap != '1)
      d.gap = q.gap + W'(1);
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      q <= '{prev_n: 1'b1, gap: '1};
    else
      q <= d;
  end

endmodule : ddic_step_mon

`default_nettype wire

// File: core/ddic_top.sv
// Purpose: Drive-side interface control: select, recalibrate, seek, heads
// Assumes: Cable inputs synchronous to pclk; APB slave with one wait state
// Notes:   Cable control lines are active low; outputs idle high
//
// The implementer's own choices: the APB interface to the registers and the register offsets.

`timescale 1ns/100ps
`default_nettype none

// Overview of operation
// - At nominal spindle speed, recalibrate heads to cylinder zero unprompted.
// - After recalibration raise outer-track flag, then ready and settled, under 30 us.
// - Ready output stays inactive while any fault is present.
// - Reads, writes and seeks are refused until ready is set.
// - Outer-track, ready and settled outputs appear only while selected.
// - Selected when the unit-select line of our address is active.
// - Radial option makes the drive permanently selected.
// - Each accepted seek pulse moves the heads one cylinder, never past cylinder 0 or 644.
// - Direction line high means inward, low means outward.
// - Seeks come as timed pulses 3 ms apart or as a faster buffer.
// - Tell timed from buffered; buffered seeks use drive-paced carriage travel.
// - Host drives binary head number; drive enables that head.
// - Read needs selection, write gate off, ready, settled, no fault.
// - Write needs selection, head, ready, settled, no fault, then write gate.
// - Cylinder range is 645 per head, counted from the outer track.
// - Serial flux data run at five megabits per second.
// - Drive detects faults internally and reports them to the host.
// - Multiplexed controls and unit selects are active low.
// - Settled drops within 100 ns of the first seek pulse.
// - Fault latches until power loss or deselection.
// - No lines active selects head zero; deselect or bad address drops heads.
module ddic_top
  import ddic_pkg::*;
#(
  parameter int STEP_CYC_P   = STEP_CYC,
  parameter int SETTLE_CYC_P = SETTLE_CYC,
  parameter int QUIET_CYC_P  = QUIET_CYC,
  parameter int MOVE_CYC_P   = MOVE_CYC,
  parameter int NUM_HEADS_P  = NUM_HEADS
) (
  input  wire logic              pclk,
  input  wire logic              presetn,
  input  wire logic              psel,
  input  wire logic              penable,
  input  wire logic              pwrite,
  input  wire logic [11:0]       paddr,
  input  wire logic [31:0]       pwdata,
  output logic      [31:0]       prdata,
  output logic                   pready,
  output logic                   pslverr,
  input  wire logic [3:0]        unit_sel_n,
  input  wire logic              step_n,
  input  wire logic              dir_in_n,
  input  wire logic              write_gate_n,
  input  wire logic [HEAD_W-1:0] head_sel_n,
  input  wire logic              flux_write_stream,
  input  wire logic              spindle_ok,
  input  wire logic              power_ok,
  input  wire logic              wr_current_sense,
  input  wire logic              head_open_short,
  input  wire logic              head_flux_rd,
  output logic                   flux_read_stream,
  output logic                   head_flux_wr,
  output logic                   head_wr_gate,
  output logic      [7:0]        head_en,
  output logic                   seek_done_n,
  output logic                   trk0_n,
  output logic                   ready_n,
  output logic                   fault_n,
  output logic                   drive_sel_n
);

  localparam int TW = 18;

  typedef struct packed {
    ddic_state_t st;
    logic [9:0]  cyl;
    logic [9:0]  tgt;
    logic        buffered;
    logic        seek_done;
    logic        ready;
    logic        trk0;
    logic        fault;
    logic [4:0]  cause;
    logic [7:0]  head_en;
    logic        wr_en;
    logic        wr_en_dly;
    logic        flux_prev;
    logic        flux_rd;
    logic        flux_wr;
    logic        seek_done_n;
    logic        trk0_n;
    logic        ready_n;
    logic        fault_n;
    logic        dsel_n;
    logic [1:0]  unit;
    logic        radial;
    logic        pready;
    logic        pslverr;
    logic [31:0] prdata;
  } ddic_regs_t;

  ddic_regs_t q, d;

  // ---------------------------------------------------------------------
  // Selection and cable decode
  // ---------------------------------------------------------------------
  logic              sel;
  logic              wg;
  logic [HEAD_W-1:0] hnum;
  logic              legal;
  logic              step_gated_n;

  // Radial jumper overrides the unit-select match
  assign sel          = q.radial | ~unit_sel_n[q.unit];
  assign wg           = sel & ~write_gate_n;
  assign hnum         = ~head_sel_n;
  assign legal        = (32'(hnum) < NUM_HEADS_P);
  assign step_gated_n = step_n | ~sel;

  // ---------------------------------------------------------------------
  // Helpers: pulse classifier and timers
  // ---------------------------------------------------------------------
  logic          stp_pulse;
  logic          stp_fast;
  logic          stp_quiet;
  logic          mv_start;
  logic [TW-1:0] mv_load;
  logic          mv_busy;
  logic          mv_fire;
  logic          gap_start;
  logic          gap_fire;
  logic          wd_start;
  logic          wd_fire;

  ddic_step_mon #(
    .W         (TW),
    .STEP_CYC  (STEP_CYC_P),
    .QUIET_CYC (QUIET_CYC_P)
  ) u_step (
    .pclk    (pclk),
    .presetn (presetn),
    .step_n  (step_gated_n),
    .pulse   (stp_pulse),
    .fast    (stp_fast),
    .quiet   (stp_quiet)
  );

  ddic_timer #(.W(TW)) u_move (
    .pclk    (pclk),
    .presetn (presetn),
    .start   (mv_start),
    .load    (mv_load),
    .busy    (mv_busy),
    .fire    (mv_fire)
  );

  ddic_timer #(.W(11)) u_gap (
    .pclk    (pclk),
    .presetn (presetn),
    .start   (gap_start),
    .load    (11'(TRK0_LEAD_CYC - 1)), // Expiry adds one edge
    .busy    (),
    .fire    (gap_fire)
  );

  ddic_timer #(.W(8)) u_wdog (
    .pclk    (pclk),
    .presetn (presetn),
    .start   (wd_start),
    .load    (8'(NODATA_CYC)),
    .busy    (),
    .fire    (wd_fire)
  );

  // ---------------------------------------------------------------------
  // Next-state logic
  // ---------------------------------------------------------------------
  logic       step_ok;
  logic       can_move;
  logic [4:0] cond;

  // Seek pulse accepted only when ready, fault-free and not writing
  assign step_ok = stp_pulse & q.ready & ~q.fault & ~wg;

  always_comb
  begin
    d         = q;
    mv_start  = 1'b0;
    mv_load   = TW'(MOVE_CYC_P);
    gap_start = 1'b0;
    can_move  = ~mv_busy & (~q.buffered | stp_quiet);

    // Positioning sequence
    case (q.st)
      ddic_spinup:
      begin
        if (spindle_ok)
        begin
          d.st       = ddic_recal;
          d.tgt      = '0;
          d.buffered = 1'b0;
        end
      end
      ddic_recal:
      begin
        if (can_move)
        begin
          if (q.cyl != '0)
          begin
            d.cyl    = q.cyl - 10'd1;
            mv_start = 1'b1;
          end
          else
          begin
            gap_start = 1'b1;
            d.st      = ddic_gap;
          end
        end
      end
      ddic_gap:
      begin
        if (gap_fire)
        begin
          d.ready     = 1'b1;
          d.seek_done = 1'b1;
          d.st        = ddic_online;
        end
      end
      ddic_online, ddic_travel, ddic_settle:
      begin
        if (step_ok)
        begin
          d.seek_done = 1'b0;
          d.buffered  = stp_fast;
          d.st        = ddic_travel;
          if (dir_in_n)
          begin
            if (q.tgt != CYL_MAX)
              d.tgt = q.tgt + 10'd1;
          end
          else if (q.tgt != '0)
            d.tgt = q.tgt - 10'd1;
          if (q.st == ddic_settle)
          begin
            mv_start = 1'b1;                                // Abort settling
            mv_load  = TW'(1);
          end
        end
        else if (q.st == ddic_travel && can_move)
        begin
          // Carriage paced by the drive, one cylinder per interval
          mv_start = 1'b1;
          if (q.cyl != q.tgt)
            d.cyl = (q.cyl < q.tgt) ? q.cyl + 10'd1 : q.cyl - 10'd1;
          else
          begin
            mv_load = TW'(SETTLE_CYC_P);
            d.st    = ddic_settle;
          end
        end
        else if (q.st == ddic_settle && mv_fire)
        begin
          d.seek_done = 1'b1;
          d.buffered  = 1'b0;
          d.st        = ddic_online;
        end
      end
      default:
        d.st = ddic_spinup;
    endcase

    // Loss of power or speed restarts the whole power-up sequence
    if (!power_ok || !spindle_ok)
    begin
      d.st        = ddic_spinup;
      d.ready     = 1'b0;
      d.seek_done = 1'b0;
    end
    d.trk0 = (d.cyl == '0) && (d.st != ddic_spinup)
             && (d.st != ddic_recal);

    // Head enables and data paths
    d.head_en   = (sel && legal) ? 8'(8'h01 << hnum) : 8'h00;
    d.wr_en     = wg & q.ready & q.seek_done & ~q.fault
                  & legal & (q.st == ddic_online);
    d.wr_en_dly = q.wr_en;
    d.flux_prev = flux_write_stream;
    d.flux_wr   = d.wr_en & flux_write_stream;
    d.flux_rd   = sel & ~wg & q.ready & q.seek_done & ~q.fault
                  & (|q.head_en) & head_flux_rd;

    // Watchdog restarts on every write flux transition
    wd_start = d.wr_en & (~q.wr_en | (flux_write_stream != q.flux_prev));

    // Fault causes, sampled only in a selected drive
    cond[0] = q.wr_en & q.wr_en_dly & ~wr_current_sense;
    cond[1] = wr_current_sense & ~q.wr_en & ~q.wr_en_dly;
    cond[2] = ($countones(q.head_en) > 1);
    cond[3] = head_open_short & (|q.head_en);
    cond[4] = wd_fire & q.wr_en;
    if (!sel || !power_ok)
      d.cause = '0;
    else
      d.cause = q.cause | cond;
    d.fault = |d.cause;

    // Cable outputs, idle high unless selected
    d.ready_n     = ~(sel & d.ready & ~d.fault);
    d.seek_done_n = ~(sel & d.seek_done);
    d.trk0_n      = ~(sel & d.trk0);
    d.fault_n     = ~(sel & d.fault);
    d.dsel_n      = ~sel;

    // APB slave: answer on the second access cycle
    d.pready = 1'b0;
    if (psel && penable && !q.pready)
    begin
      d.pready  = 1'b1;
      d.pslverr = 1'b0;
      d.prdata  = '0;
      case (paddr)
        REG_CTRL:
        begin
          d.prdata[CTRL_UNIT +: 2] = q.unit;
          d.prdata[CTRL_RADIAL]    = q.radial;
        end
        REG_STATUS:
        begin
          d.prdata[ST_READY]      = q.ready;
          d.prdata[ST_SEEKDONE]   = q.seek_done;
          d.prdata[ST_TRK0]       = q.trk0;
          d.prdata[ST_FAULT]      = q.fault;
          d.prdata[ST_SEL]        = sel;
          d.prdata[ST_BUFFERED]   = q.buffered;
          d.prdata[ST_WREN]       = q.wr_en;
          d.prdata[ST_STATE +: 3] = q.st;
          d.prdata[ST_HEADS +: 8] = q.head_en;
        end
        REG_CYL:
        begin
          d.prdata[CYL_CUR +: CYL_W] = q.cyl;
          d.prdata[CYL_TGT +: CYL_W] = q.tgt;
        end
        REG_FAULT:
          d.prdata[4:0] = q.cause;
        default:
          d.pslverr = 1'b1;
      endcase
    end
    if (psel && penable && q.pready && pwrite && paddr == REG_CTRL)
    begin
      d.unit   = pwdata[CTRL_UNIT +: 2];
      d.radial = pwdata[CTRL_RADIAL];
    end
  end

  // ---------------------------------------------------------------------
  // State register
  // ---------------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      q             <= '0;
      q.st          <= ddic_spinup;
      q.cyl         <= CYL_MAX;   // Position unknown until recalibrated
      q.tgt         <= CYL_MAX;
      q.seek_done_n <= 1'b1;
      q.trk0_n      <= 1'b1;
      q.ready_n     <= 1'b1;
      q.fault_n     <= 1'b1;
      q.dsel_n      <= 1'b1;
      q.unit        <= RST_UNIT;
      q.radial      <= RST_RADIAL;
    end
    else
      q <= d;
  end

  // Outputs straight from the state register
  assign prdata           = q.prdata;
  assign pready           = q.pready;
  assign pslverr          = q.pslverr;
  assign flux_read_stream = q.flux_rd;
  assign head_flux_wr     = q.flux_wr;
  assign head_wr_gate     = q.wr_en;
  assign head_en          = q.head_en;
  assign seek_done_n      = q.seek_done_n;
  assign trk0_n           = q.trk0_n;
  assign ready_n          = q.ready_n;
  assign fault_n          = q.fault_n;
  assign drive_sel_n      = q.dsel_n;

endmodule : ddic_top

`default_nettype wire

// File: verification/ddic_assertions.sv
// Purpose: Port checks of the drive control block
// Assumes: Bound to ddic_top, single pclk domain
// Notes:   Cable outputs are active low
`timescale 1ns/100ps
`default_nettype none
module ddic_assertions
  import ddic_pkg::*;
(
  input wire logic              pclk,
  input wire logic              presetn,
  input wire logic              psel,
  input wire logic              penable,
  input wire logic [11:0]       paddr,
  input wire logic              pready,
  input wire logic              pslverr,
  input wire logic              step_n,
  input wire logic              write_gate_n,
  input wire logic [HEAD_W-1:0] head_sel_n,
  input wire logic              flux_write_stream,
  input wire logic              head_flux_rd,
  input wire logic              flux_read_stream,
  input wire logic              head_flux_wr,
  input wire logic              head_wr_gate,
  input wire logic [7:0]        head_en,
  input wire logic              seek_done_n,
  input wire logic              trk0_n,
  input wire logic              ready_n,
  input wire logic              fault_n
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  // ---------------------------------------------------------------------
  // Status, seek, head and APB checks
  // ---------------------------------------------------------------------
  a_fault_ready: assert property (!fault_n && !$past(fault_n) |-> ready_n)
    else $error("ready shown during fault");
  // Cycles since the outer flag fell while ready is still held off
  logic [10:0] lead_cnt;
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      lead_cnt <= '0;
    else if ($fell(trk0_n) && ready_n)
      lead_cnt <= 11'h001;
    else if (lead_cnt != '0 && ready_n && !trk0_n)
      lead_cnt <= lead_cnt + 11'h001;
    else
      lead_cnt <= '0;
  end
  a_trk0_lead: assert property (lead_cnt != '0 |-> lead_cnt < 11'h4B0
    && (ready_n || (lead_cnt > 11'h3E8 && !seek_done_n)))
    else $error("outer flag to ready gap wrong");
  a_step_drop: assert property (!step_n && $past(step_n) && !ready_n
    && fault_n && write_gate_n |=> seek_done_n)
    else $error("settled not dropped on step");
  a_move_hold: assert property ($rose(seek_done_n) && !ready_n
    |-> seek_done_n [*8])
    else $error("move ended too soon");
  a_head_bad: assert property (head_sel_n == 3'h0 |=> head_en == 8'h00)
    else $error("illegal head enabled");
  a_head_map: assert property (head_en != 8'h00 |->
    head_en == 8'h01 << ~$past(head_sel_n))
    else $error("wrong head enabled");
  a_wgate_cond: assert property (head_wr_gate |-> !$past(write_gate_n)
    && !$past(ready_n) && !$past(seek_done_n))
    else $error("write gate without conditions");
  a_wr_copy: assert property (head_wr_gate && $past(head_wr_gate)
    |-> head_flux_wr == $past(flux_write_stream))
    else $error("write flux not passed");
  a_rd_gate: assert property (flux_read_stream |-> $past(head_flux_rd)
    && $past(write_gate_n))
    else $error("read flux not gated");
  a_apb_wait: assert property (psel && penable && !$past(penable) |=> pready)
    else $error("apb answer late");
  a_apb_err: assert property (pready && paddr > 12'h00C |-> pslverr)
    else $error("unmapped access accepted");
  c_power: cover property ($fell(trk0_n));
  c_seek: cover property ($rose(seek_done_n));
  c_write: cover property ($rose(head_wr_gate));
  c_fault: cover property ($fell(fault_n));
endmodule : ddic_assertions
bind ddic_top ddic_assertions u_chk (.pclk, .presetn, .psel, .penable,
  .paddr, .pready, .pslverr, .step_n, .write_gate_n, .head_sel_n,
  .flux_write_stream, .head_flux_rd, .flux_read_stream, .head_flux_wr,
  .head_wr_gate, .head_en, .seek_done_n, .trk0_n, .ready_n, .fault_n);
`default_nettype wire

// File: verification/ddic_mech_model.sv
// Purpose: Spindle, supplies and head channel behind the drive logic
// Assumes: Write current follows the gate one cycle late
// Notes:   Read flux toggles once per cell
`timescale 1ns/100ps
`default_nettype none
module ddic_mech_model
  import ddic_pkg::*;
(
  input  wire logic pclk,
  input  wire logic head_wr_gate,
  output logic      spindle_ok,
  output logic      power_ok,
  output logic      wr_current_sense,
  output logic      head_flux_rd
);
  int cnt = 0;
  initial
  begin
    {spindle_ok, power_ok, wr_current_sense, head_flux_rd} = 4'h0;
  end
  // Spin-up after a short delay, current sense, flux at cell rate
  always @(posedge pclk)
  begin
    cnt <= cnt + 1;
    power_ok <= 1'h1;
    spindle_ok <= (cnt > 100);
    wr_current_sense <= head_wr_gate;
    if (cnt % FLUX_CELL_CYC == 0)
      head_flux_rd <= ~head_flux_rd;
  end
endmodule : ddic_mech_model
`default_nettype wire

// File: verification/ddic_tb_top.sv
// Purpose: Directed bench of the drive control block
// Assumes: Short step, settle and quiet counts
// Notes:   Power-up recalibration walks the full cylinder range
`timescale 1ns/100ps
`default_nettype none
module ddic_tb_top;
  import ddic_pkg::*;
  localparam int LIMIT = 60000;
  logic        pclk = '0, presetn = '0, psel = '0, penable = '0, pwrite = '0;
  logic [11:0] paddr = '0;
  logic [31:0] pwdata = '0, prdata, q;
  logic        pready, pslverr, e, flux_read_stream, head_flux_wr;
  logic        head_wr_gate, seek_done_n, trk0_n, ready_n, fault_n;
  logic        drive_sel_n, step_n = '1, dir_in_n = '1, write_gate_n = '1;
  logic        flux_write_stream = '0, head_open_short = '0;
  logic [7:0]  head_en;
  logic [3:0]  unit_sel_n = 4'hF;
  logic [2:0]  head_sel_n = 3'h7;
  wire         spindle_ok, power_ok, wr_current_sense, head_flux_rd;
  int          fail_count = 0, n_checks = 0, cyc = 0, n, m;

  ddic_top #(.STEP_CYC_P(200), .SETTLE_CYC_P(100), .QUIET_CYC_P(50),
    .MOVE_CYC_P(20)) DUT (
    .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
    .pready, .pslverr, .unit_sel_n, .step_n, .dir_in_n, .write_gate_n,
    .head_sel_n, .flux_write_stream, .spindle_ok, .power_ok,
    .wr_current_sense, .head_open_short, .head_flux_rd, .flux_read_stream,
    .head_flux_wr, .head_wr_gate, .head_en, .seek_done_n, .trk0_n,
    .ready_n, .fault_n, .drive_sel_n);
  ddic_mech_model u_mech (.pclk, .head_wr_gate, .spindle_ok, .power_ok,
    .wr_current_sense, .head_flux_rd);

  always #12.5 pclk = ~pclk;

  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp)
    begin
      fail_count++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : check

  task automatic look(input int k);
    repeat (k) @(posedge pclk);
    @(negedge pclk);
  endtask : look

  // One APB transfer; answer taken at the edge that samples pready
  task automatic apb(input logic w, input logic [11:0] a,
                     input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'h1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'h1;
    @(posedge pclk);
    while (pready !== 1'h1) @(posedge pclk);
    q = prdata;
    e = pslverr;
    psel <= 1'h0;
    penable <= 1'h0;
  endtask : apb

  task automatic cyl(input logic [9:0] x);
    apb(1'h0, REG_CYL, '0);
    check(q & 32'h3FF, 32'(x));
  endtask : cyl

  // Direction first, then k pulses, then wait for settling
  task automatic seek(input logic d, input int k, input logic [9:0] x);
    int i;
    @(posedge pclk);
    dir_in_n <= d;
    repeat (k)
    begin
      @(posedge pclk);
      step_n <= 1'h0;
      repeat (3) @(posedge pclk);
      step_n <= 1'h1;
      repeat (3) @(posedge pclk);
    end
    for (i = 0; seek_done_n !== 1'h0 && i < 20000; i++) look(0);
    cyl(x);
  endtask : seek

  task automatic results;
    $display("Checks %0d, mismatches %0d", n_checks, fail_count);
    if (fail_count == 0 && n_checks > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask : results

  // Cuts a hang short
  always @(posedge pclk)
  begin
    cyc <= cyc + 1;
    if (cyc == LIMIT)
    begin
      fail_count++;
      results();
    end
  end

  // Main sequence
  initial
  begin
    repeat (8) @(posedge pclk);
    presetn <= 1'h1;
    look(1);
    check({ready_n, trk0_n, fault_n}, 3'h7);
    apb(1'h0, REG_CTRL, '0);
    check(q, '0);
    apb(1'h0, 12'h010, '0);
    check(e, 1'h1);
    @(posedge pclk);
    unit_sel_n <= 4'hE;
    while (trk0_n !== 1'h0) look(0);
    check(ready_n, 1'h1);
    for (n = 0; ready_n !== 1'h0; n++) look(0);
    check(32'(n > 0 && n < 1200), 1);
    check(seek_done_n, 1'h0);
    cyl(10'h0);
    seek(1'h1, 1, 10'h1);
    seek(1'h0, 1, 10'h0);
    seek(1'h0, 1, 10'h0);
    seek(1'h1, 3, 10'h3);
    for (n = 0; n < 8; n++)
    begin
      @(posedge pclk);
      head_sel_n <= ~3'(n);
      look(2);
      check(head_en, n < 7 ? 8'h01 << n : 8'h00);
    end
    @(posedge pclk);
    head_sel_n <= 3'h7;
    look(2);
    e = flux_read_stream;
    m = 0;
    repeat (80)
    begin
      look(0);
      m += int'(flux_read_stream !== e);
      e = flux_read_stream;
    end
    check(m, 10);
    @(posedge pclk);
    unit_sel_n <= 4'hD;
    look(2);
    check({ready_n, trk0_n, seek_done_n, head_en}, 11'h700);
    check(drive_sel_n, 1'h1);
    seek(1'h1, 1, 10'h3);
    apb(1'h1, REG_CTRL, 32'h4);
    look(2);
    check({ready_n, drive_sel_n}, 2'h0);
    seek(1'h1, 1, 10'h4);
    apb(1'h1, REG_CTRL, '0);
    @(posedge pclk);
    unit_sel_n <= 4'hE;
    head_open_short <= 1'h1;
    look(3);
    check({fault_n, ready_n}, 2'h1);
    @(posedge pclk);
    head_open_short <= 1'h0;
    seek(1'h1, 1, 10'h4);
    check(fault_n, 1'h0);
    @(posedge pclk);
    unit_sel_n <= 4'hF;
    look(2);
    @(posedge pclk);
    unit_sel_n <= 4'hE;
    look(2);
    check({fault_n, ready_n}, 2'h2);
    @(posedge pclk);
    write_gate_n <= 1'h0;
    repeat (9)
    begin
      repeat (3) @(posedge pclk);
      flux_write_stream <= ~flux_write_stream;
    end
    look(1);
    check({head_wr_gate, fault_n, flux_read_stream}, 3'h6);
    check(head_flux_wr, flux_write_stream);
    apb(1'h0, REG_STATUS, '0);
    check(q & 32'h7F, 32'h53);
    look(140);
    check(fault_n, 1'h0);
    @(posedge pclk);
    write_gate_n <= 1'h1;
    results();
  end
endmodule : ddic_tb_top
`default_nettype wire
